// ===== logic/pwm_ctl_pkg.sv
// Package for the PWM output and trigger control slice.
// Assumes a 32-bit Avalon-MM register bus and a 50 MHz system clock.
`default_nettype none

package pwm_ctl_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_TRIG_CTRL  = 5'h00;
  localparam logic [4:0] OFS_OUT_CTRL   = 5'h04;
  localparam logic [4:0] OFS_LIMIT_CTRL = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT   = 5'h0C;
  localparam logic [4:0] OFS_IRQ_CLEAR  = 5'h10;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h14;

  // Reset values
  localparam logic [15:0] TRIG_RESET  = 16'h0000;
  localparam logic [15:0] OUT_RESET   = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;

  // Writable bit masks; all other positions read as zero
  localparam logic [15:0] TRIG_WMASK  = 16'hE03F;
  localparam logic [15:0] OUT_WMASK   = 16'hFFFD;
  localparam logic [15:0] LIMIT_WMASK = 16'h1FFF;

  // Trigger control fields
  localparam int TRIG_DIV_LSB   = 13;
  localparam int TRIG_START_LSB = 0;

  // Output control fields
  localparam int OUT_HIGH_OWN   = 15;
  localparam int OUT_LOW_OWN    = 14;
  localparam int OUT_HIGH_INV   = 13;
  localparam int OUT_LOW_INV    = 12;
  localparam int OUT_MODE_LSB   = 10;
  localparam int OUT_HIGH_FORCE = 9;
  localparam int OUT_LOW_FORCE  = 8;
  localparam int OUT_FVAL_LSB   = 6;
  localparam int OUT_TVAL_LSB   = 4;
  localparam int OUT_LVAL_LSB   = 2;
  localparam int OUT_ALIGN      = 0;

  // Limit control fields
  localparam int LIM_SRC_LSB    = 9;
  localparam int LIM_INV        = 8;
  localparam int LIM_EN         = 7;
  localparam int TRIP_SRC_LSB   = 3;
  localparam int TRIP_INV       = 2;
  localparam int TRIP_MODE_LSB  = 0;

  // Interrupt status bits
  localparam int IRQ_TRIG  = 0;
  localparam int IRQ_LIMIT = 1;
  localparam int IRQ_TRIP  = 2;

  // Number of asynchronous limit and trip sources
  localparam int NUM_SRC = 10;

  // Pin pair modes
  typedef enum logic [1:0] {
    MODE_COMPL  = 2'b00,
    MODE_INDEP  = 2'b01,
    MODE_PUSH   = 2'b10,
    MODE_RSVD   = 2'b11
  } pair_mode_t;

  // Trip modes
  localparam logic [1:0] TRIP_MODE_FORCE = 2'b01;
  localparam logic [1:0] TRIP_MODE_OFF   = 2'b11;

  // High and low signal of one pin pair
  typedef struct packed {
    logic high;
    logic low;
  } pin_pair_t;

endpackage

`default_nettype wire

// ===== logic/pwm_output_trigger_control.sv
// PWM output pin control, current limit / trip selection and trigger postscaler.
// Assumes generator signals, roll count and trigger events come from logic on clk_i;
// comparator and fault inputs are asynchronous and are synchronised here.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwm_output_trigger_control (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Generator side, same clock
  input  wire pwm_ctl_pkg::pin_pair_t gen_pair_i,
  input  wire pwm_ctl_pkg::pin_pair_t gpio_pair_i,
  input  wire logic                  tb_period_i,
  input  wire logic [5:0]            roll_count_i,
  input  wire logic                  trig_event_i,
  // Asynchronous limit and trip sources
  input  wire logic [3:0]            comparator_i,
  input  wire logic [3:0]            shared_trip_i,
  input  wire logic [1:0]            local_trip_i,
  // Pins and status
  output logic                       out_high_pin_o,
  output logic                       out_low_pin_o,
  output logic                       trig_out_o,
  output logic                       limit_active_o,
  output logic                       trip_active_o,
  output logic                       irq_o
);

  logic [15:0] trig_q;
  logic [15:0] out_q;
  logic [15:0] lim_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_en_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc_wr;
  logic [15:0] wdata16;
  logic [15:0] wmask16;
  logic [pwm_ctl_pkg::NUM_SRC-1:0] src_raw;
  logic [pwm_ctl_pkg::NUM_SRC-1:0] sync1_q;
  logic [pwm_ctl_pkg::NUM_SRC-1:0] sync2_q;
  logic        limit_act_q;
  logic        trip_act_q;
  logic        armed_q;
  logic [2:0]  div_cnt_q;
  logic        trig_pulse_q;
  logic [2:0]  div_sel;
  logic [5:0]  start_sel;
  logic [1:0]  force_eff_q;
  logic [1:0]  force_val_eff_q;
  logic        push_phase_q;
  pwm_ctl_pkg::pin_pair_t mode_pair;
  pwm_ctl_pkg::pin_pair_t pri_pair;
  pwm_ctl_pkg::pin_pair_t pin_d;
  logic        limit_d;
  logic        trip_d;
  logic [2:0]  irq_set;

  // Source map shared by limit and trip selectors; reserved codes give zero
  function automatic logic pick_src(input logic [3:0] code,
                                    input logic [pwm_ctl_pkg::NUM_SRC-1:0] srcs);
    logic r;
    r = 1'b0;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3: r = srcs[code[1:0]];
      4'h8:    r = srcs[4];
      4'h9:    r = srcs[5];
      4'hA:    r = srcs[6];
      4'hB:    r = srcs[7];
      4'hD:    r = srcs[8];
      4'hF:    r = srcs[9];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Bus request accepted on the edge where waitrequest is low
  assign acc_wr  = avs_write_i & ~wait_q;
  assign wdata16 = avs_writedata_i[15:0];
  assign wmask16 = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // One wait state per access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i | avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Control registers, masked so unimplemented bits stay zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trig_q <= pwm_ctl_pkg::TRIG_RESET;
      out_q  <= pwm_ctl_pkg::OUT_RESET;
      lim_q  <= pwm_ctl_pkg::LIMIT_RESET;
    end else if (acc_wr) begin
      case (avs_address_i)
        pwm_ctl_pkg::OFS_TRIG_CTRL: begin
          trig_q <= ((trig_q & ~wmask16) | (wdata16 & wmask16)) & pwm_ctl_pkg::TRIG_WMASK;
        end
        pwm_ctl_pkg::OFS_OUT_CTRL: begin
          out_q <= ((out_q & ~wmask16) | (wdata16 & wmask16)) & pwm_ctl_pkg::OUT_WMASK;
        end
        pwm_ctl_pkg::OFS_LIMIT_CTRL: begin
          lim_q <= ((lim_q & ~wmask16) | (wdata16 & wmask16)) & pwm_ctl_pkg::LIMIT_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_en_q <= pwm_ctl_pkg::IRQ_RESET;
    end else if (acc_wr && avs_address_i == pwm_ctl_pkg::OFS_IRQ_ENABLE && avs_byteenable_i[0]) begin
      irq_en_q <= avs_writedata_i[2:0];
    end
  end

  // Read data latched one cycle ahead so it stands when waitrequest drops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      case (avs_address_i)
        pwm_ctl_pkg::OFS_TRIG_CTRL:  rdata_q <= {16'h0000, trig_q};
        pwm_ctl_pkg::OFS_OUT_CTRL:   rdata_q <= {16'h0000, out_q};
        pwm_ctl_pkg::OFS_LIMIT_CTRL: rdata_q <= {16'h0000, lim_q};
        pwm_ctl_pkg::OFS_IRQ_STAT:   rdata_q <= {29'h0000_0000, irq_stat_q};
        pwm_ctl_pkg::OFS_IRQ_ENABLE: rdata_q <= {29'h0000_0000, irq_en_q};
        default:                     rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // Two-flop synchronisers for the asynchronous sources
  assign src_raw = {local_trip_i, shared_trip_i, comparator_i};

  generate
    for (genvar i = 0; i < pwm_ctl_pkg::NUM_SRC; i++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= src_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  // Limit and trip detection from the selected, polarity-corrected source
  always_comb begin
    limit_d = lim_q[pwm_ctl_pkg::LIM_EN] &
              (pick_src(lim_q[pwm_ctl_pkg::LIM_SRC_LSB +: 4], sync2_q) ^
               lim_q[pwm_ctl_pkg::LIM_INV]);
    trip_d  = (lim_q[pwm_ctl_pkg::TRIP_MODE_LSB +: 2] == pwm_ctl_pkg::TRIP_MODE_FORCE) &
              (pick_src(lim_q[pwm_ctl_pkg::TRIP_SRC_LSB +: 4], sync2_q) ^
               lim_q[pwm_ctl_pkg::TRIP_INV]);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      limit_act_q <= 1'b0;
      trip_act_q  <= 1'b0;
    end else begin
      limit_act_q <= limit_d;
      trip_act_q  <= trip_d;
    end
  end

  assign limit_active_o = limit_act_q;
  assign trip_active_o  = trip_act_q;

  // Trigger postscaler: arm on roll match, then pass every (divider+1)th event
  assign div_sel   = trig_q[pwm_ctl_pkg::TRIG_DIV_LSB +: 3];
  assign start_sel = trig_q[pwm_ctl_pkg::TRIG_START_LSB +: 6];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      armed_q      <= 1'b0;
      div_cnt_q    <= 3'h0;
      trig_pulse_q <= 1'b0;
    end else if (acc_wr && avs_address_i == pwm_ctl_pkg::OFS_TRIG_CTRL) begin
      armed_q      <= 1'b0;
      div_cnt_q    <= 3'h0;
      trig_pulse_q <= 1'b0;
    end else begin
      trig_pulse_q <= 1'b0;
      if (!armed_q && roll_count_i == start_sel) begin
        armed_q <= 1'b1;
      end
      if (armed_q && trig_event_i) begin
        if (div_cnt_q == div_sel) begin
          div_cnt_q    <= 3'h0;
          trig_pulse_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
      end
    end
  end

  assign trig_out_o = trig_pulse_q;

  // Force enables and values, optionally taken only at the time base period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      force_eff_q     <= 2'b00;
      force_val_eff_q <= 2'b00;
    end else if (!out_q[pwm_ctl_pkg::OUT_ALIGN] || tb_period_i) begin
      force_eff_q     <= {out_q[pwm_ctl_pkg::OUT_HIGH_FORCE], out_q[pwm_ctl_pkg::OUT_LOW_FORCE]};
      force_val_eff_q <= out_q[pwm_ctl_pkg::OUT_FVAL_LSB +: 2];
    end
  end

  // Push-pull phase alternates every time base period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      push_phase_q <= 1'b0;
    end else if (tb_period_i) begin
      push_phase_q <= ~push_phase_q;
    end
  end

  // Pin pair mode shaping of the generator output
  always_comb begin
    case (pwm_ctl_pkg::pair_mode_t'(out_q[pwm_ctl_pkg::OUT_MODE_LSB +: 2]))
      pwm_ctl_pkg::MODE_COMPL: begin
        mode_pair.high = gen_pair_i.high;
        mode_pair.low  = ~gen_pair_i.high;
      end
      pwm_ctl_pkg::MODE_INDEP: begin
        mode_pair = gen_pair_i;
      end
      pwm_ctl_pkg::MODE_PUSH: begin
        mode_pair.high = gen_pair_i.high & ~push_phase_q;
        mode_pair.low  = gen_pair_i.high & push_phase_q;
      end
      default: begin
        mode_pair = '{high: 1'b0, low: 1'b0};
      end
    endcase
  end

  // Source priority, polarity and ownership for both pins
  always_comb begin
    if (trip_act_q) begin
      pri_pair = out_q[pwm_ctl_pkg::OUT_TVAL_LSB +: 2];
    end else if (limit_act_q) begin
      pri_pair = out_q[pwm_ctl_pkg::OUT_LVAL_LSB +: 2];
    end else begin
      pri_pair.high = force_eff_q[1] ? force_val_eff_q[1] : mode_pair.high;
      pri_pair.low  = force_eff_q[0] ? force_val_eff_q[0] : mode_pair.low;
    end
    pin_d.high = out_q[pwm_ctl_pkg::OUT_HIGH_OWN] ?
                 (pri_pair.high ^ out_q[pwm_ctl_pkg::OUT_HIGH_INV]) :
                 gpio_pair_i.high;
    pin_d.low  = out_q[pwm_ctl_pkg::OUT_LOW_OWN] ?
                 (pri_pair.low ^ out_q[pwm_ctl_pkg::OUT_LOW_INV]) :
                 gpio_pair_i.low;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_high_pin_o <= 1'b0;
      out_low_pin_o  <= 1'b0;
    end else begin
      out_high_pin_o <= pin_d.high;
      out_low_pin_o  <= pin_d.low;
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle
  assign irq_set[pwm_ctl_pkg::IRQ_TRIG]  = trig_pulse_q;
  assign irq_set[pwm_ctl_pkg::IRQ_LIMIT] = limit_d & ~limit_act_q;
  assign irq_set[pwm_ctl_pkg::IRQ_TRIP]  = trip_d & ~trip_act_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= pwm_ctl_pkg::IRQ_RESET;
    end else if (acc_wr && avs_address_i == pwm_ctl_pkg::OFS_IRQ_CLEAR && avs_byteenable_i[0]) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata_i[2:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_trig_div_count: assert property (
    (armed_q && trig_event_i && div_cnt_q == div_sel && !acc_wr) |=> trig_out_o)
    else $error("Trigger output missing at divider terminal count");

  a_trig_no_early: assert property (
    (armed_q && trig_event_i && div_cnt_q != div_sel) |=> !trig_out_o)
    else $error("Trigger output before divider count reached");

  a_trig_needs_arm: assert property (!armed_q |=> !trig_out_o)
    else $error("Trigger output while postscaler not armed");

  a_reserved_zero: assert property (
    ((trig_q & ~pwm_ctl_pkg::TRIG_WMASK) == 16'h0000) &&
    ((out_q & ~pwm_ctl_pkg::OUT_WMASK) == 16'h0000) &&
    ((lim_q & ~pwm_ctl_pkg::LIMIT_WMASK) == 16'h0000))
    else $error("Unimplemented control bit became set");

  a_high_gpio_pass: assert property (
    !out_q[pwm_ctl_pkg::OUT_HIGH_OWN] |=> out_high_pin_o == $past(gpio_pair_i.high))
    else $error("High pin not following GPIO when unowned");

  a_low_gpio_pass: assert property (
    !out_q[pwm_ctl_pkg::OUT_LOW_OWN] |=> out_low_pin_o == $past(gpio_pair_i.low))
    else $error("Low pin not following GPIO when unowned");

  a_trip_pin_value: assert property (
    (trip_act_q && out_q[pwm_ctl_pkg::OUT_HIGH_OWN]) |=>
    out_high_pin_o == ($past(out_q[pwm_ctl_pkg::OUT_TVAL_LSB + 1]) ^ $past(out_q[pwm_ctl_pkg::OUT_HIGH_INV])))
    else $error("High pin not at trip value during trip");

  a_limit_pin_value: assert property (
    (!trip_act_q && limit_act_q && out_q[pwm_ctl_pkg::OUT_LOW_OWN]) |=>
    out_low_pin_o == ($past(out_q[pwm_ctl_pkg::OUT_LVAL_LSB]) ^ $past(out_q[pwm_ctl_pkg::OUT_LOW_INV])))
    else $error("Low pin not at limit value during limit");

  a_force_hold_align: assert property (
    (out_q[pwm_ctl_pkg::OUT_ALIGN] && !tb_period_i) |=> $stable(force_eff_q))
    else $error("Aligned force changed away from time base period");

  a_limit_off_idle: assert property (!lim_q[pwm_ctl_pkg::LIM_EN] |=> !limit_active_o)
    else $error("Limit active while limit function disabled");

  a_trip_off_idle: assert property (
    (lim_q[pwm_ctl_pkg::TRIP_MODE_LSB +: 2] == pwm_ctl_pkg::TRIP_MODE_OFF) |=> !trip_active_o)
    else $error("Trip active while trip input disabled");

  c_trig_pass: cover property (armed_q && trig_event_i ##1 trig_out_o);
  c_trip_force: cover property (trip_act_q && out_q[pwm_ctl_pkg::OUT_HIGH_OWN]);
  c_irq_raise: cover property (!irq_o ##1 irq_o);
  c_read_done: cover property (avs_read_i && wait_q ##1 !avs_waitrequest_o);

endmodule

`default_nettype wire

// ===== testbench/power_stage_model.sv
// Behavioural far side: analog comparators and fault lines feeding the slice.
// Assumes the bench sets the wanted source levels; the lines move off the clock.
`timescale 1ns/1ps
`default_nettype none

module power_stage_model #(
  parameter int DELAY_NS = 3
) (
  // Wanted source levels {local faults, shared faults, comparators}
  input  wire logic [9:0] src_cmd_i,
  // Source lines toward the slice
  output wire logic [3:0] comparator_o,
  output wire logic [3:0] shared_trip_o,
  output wire logic [1:0] local_trip_o
);
  // Sources settle a few ns after the command, unrelated to the clock edge
  assign #(DELAY_NS) {local_trip_o, shared_trip_o, comparator_o} = src_cmd_i;
endmodule

`default_nettype wire

// ===== testbench/pwm_output_trigger_control_test.sv
// Self-checking bench for the PWM output, limit, trip and trigger slice.
// Assumes the power stage model drives the asynchronous source lines.
`timescale 1ns/1ps
`default_nettype none

module pwm_output_trigger_control_test;
  typedef struct packed {logic [4:0] a; logic [3:0] b; logic [31:0] d; logic [31:0] e;} reg_row_t;
  typedef struct packed {logic [15:0] c; logic [1:0] g; logic [1:0] p; logic [1:0] x;} pin_row_t;
  logic                   clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic [4:0]             adr = 5'h00;
  logic                   rd = 1'b0;
  logic                   wr = 1'b0;
  logic [31:0]            wd = 32'h0;
  logic [3:0]             be = 4'hF;
  logic [31:0]            rdata;
  logic                   wait_o;
  pwm_ctl_pkg::pin_pair_t gen = '0;
  pwm_ctl_pkg::pin_pair_t gpio = '0;
  logic                   tb_per = 1'b0;
  logic [5:0]             roll = 6'h3F;
  logic                   trig_ev = 1'b0;
  logic [9:0]             src = '0;
  logic [3:0]             comp;
  logic [3:0]             strip;
  logic [1:0]             ltrip;
  logic                   hi, lo, trig, lim, trip, irq;
  logic [31:0]            q;
  int                     fail_count = 0;
  int                     n_checks = 0;
  int                     cycles = 0;
  int                     trig_seen = 0;
  int                     base;
  logic [3:0]             codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF};
  reg_row_t regs [8] = '{'{5'h0C, 4'hF, 32'hFFFFFFFF, 32'h0}, '{5'h18, 4'hF, 32'hFFFFFFFF, 32'h0},
    '{5'h00, 4'hF, 32'hFFFFFFFF, 32'hE03F}, '{5'h04, 4'hF, 32'hFFFFFFFF, 32'hFFFD},
    '{5'h08, 4'hF, 32'hFFFFFFFF, 32'h1FFF}, '{5'h14, 4'hF, 32'hFFFFFFFF, 32'h7},
    '{5'h04, 4'hF, 32'h0, 32'h0}, '{5'h04, 4'h1, 32'hFFFFFFFF, 32'h00FD}};
  pin_row_t pins [11] = '{'{16'h0000, 2'b10, 2'b01, 2'b01}, '{16'h4400, 2'b11, 2'b00, 2'b01},
    '{16'hC000, 2'b10, 2'b00, 2'b10}, '{16'hC000, 2'b01, 2'b00, 2'b01},
    '{16'hC400, 2'b11, 2'b00, 2'b11}, '{16'hC400, 2'b00, 2'b00, 2'b00},
    '{16'hF400, 2'b10, 2'b00, 2'b01}, '{16'hCC00, 2'b11, 2'b00, 2'b00},
    '{16'hC780, 2'b01, 2'b00, 2'b10}, '{16'hC640, 2'b01, 2'b00, 2'b01},
    '{16'hE780, 2'b01, 2'b00, 2'b00}};

  pwm_output_trigger_control i_pwm_output_trigger_control (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .gen_pair_i(gen), .gpio_pair_i(gpio), .tb_period_i(tb_per), .roll_count_i(roll),
    .trig_event_i(trig_ev), .comparator_i(comp), .shared_trip_i(strip), .local_trip_i(ltrip),
    .out_high_pin_o(hi), .out_low_pin_o(lo), .trig_out_o(trig), .limit_active_o(lim),
    .trip_active_o(trip), .irq_o(irq));

  power_stage_model i_power_stage_model (
    .src_cmd_i(src), .comparator_o(comp), .shared_trip_o(strip), .local_trip_o(ltrip));

  // Clock, cycle count and trigger pulse count
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (trig === 1'b1) trig_seen <= trig_seen + 1;
  end

  // Hang guard
  always @(posedge clk_i) begin
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
    cmp_word({30'h0, got}, {30'h0, exp});
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low at a rising edge;
  // read data is taken at that same edge and the request is dropped right after it
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    adr <= a;
    be <= b;
    wd <= d;
    @(posedge clk_i);
    while (wait_o !== 1'b0) @(posedge clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'hF, d);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 4'hF, 32'h0);
    cmp_word(q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic pulse_tb;
    @(posedge clk_i) tb_per <= 1'b1;
    @(posedge clk_i) tb_per <= 1'b0;
    cyc(3);
  endtask

  task automatic pulse_ev;
    @(posedge clk_i) trig_ev <= 1'b1;
    @(posedge clk_i) trig_ev <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    cmp_bits({wait_o, hi | lo | trig | irq}, 2'b10);
    foreach (regs[i]) rchk(regs[i].a, 32'h0);
    // Register table: masks, read-only status, unmapped place, byte enables
    foreach (regs[i]) begin
      bus(1'b1, regs[i].a, regs[i].b, regs[i].d);
      rchk(regs[i].a, regs[i].e);
    end
    wreg(5'h00, 32'h0);
    wreg(5'h04, 32'h0);
    wreg(5'h08, 32'h0);
    wreg(5'h14, 32'h0);
    wreg(5'h10, 32'h7);
    $display("register table done");
    // Pin ownership, polarity, pair modes and force
    foreach (pins[i]) begin
      @(posedge clk_i);
      gen <= pwm_ctl_pkg::pin_pair_t'(pins[i].g);
      gpio <= pwm_ctl_pkg::pin_pair_t'(pins[i].p);
      wreg(5'h04, {16'h0, pins[i].c});
      cyc(3);
      cmp_bits({hi, lo}, pins[i].x);
    end
    $display("pin table done");
    @(posedge clk_i) gen <= '0;
    wreg(5'h04, 32'hC400);
    wreg(5'h04, 32'hC7C1);
    cyc(4);
    cmp_bits({hi, lo}, 2'b00);
    pulse_tb();
    cmp_bits({hi, lo}, 2'b11);
    @(posedge clk_i) gen <= 2'b10;
    wreg(5'h04, 32'hC800);
    pulse_tb();
    q[1:0] = {hi, lo};
    cmp_bits({1'b0, hi ^ lo}, 2'b01);
    pulse_tb();
    cmp_bits({hi, lo}, ~q[1:0]);
    $display("align and push-pull done");
    // Every limit source code, with only that source raised
    @(posedge clk_i) gen <= '0;
    wreg(5'h04, 32'hC404);
    foreach (codes[i]) begin
      src <= 10'h1 << i;
      wreg(5'h08, {19'h0, codes[i], 9'h080});
      cyc(5);
      cmp_bits({hi, lo}, 2'b01);
      cmp_bits({1'b0, lim}, 2'b01);
    end
    src <= 10'h3FF;
    wreg(5'h08, 32'h0880);
    cyc(5);
    cmp_bits({1'b0, lim}, 2'b00);
    src <= 10'h1;
    wreg(5'h08, 32'h0000);
    cyc(5);
    cmp_bits({hi, lim}, 2'b00);
    src <= 10'h0;
    wreg(5'h08, 32'h0180);
    cyc(5);
    cmp_bits({1'b0, lim}, 2'b01);
    // Trip against limit priority
    src <= 10'h1;
    wreg(5'h04, 32'hC424);
    wreg(5'h08, 32'h0081);
    cyc(5);
    cmp_bits({hi, lo}, 2'b10);
    cmp_bits({1'b0, trip}, 2'b01);
    wreg(5'h08, 32'h0083);
    cyc(5);
    cmp_bits({hi, lo}, 2'b01);
    cmp_bits({1'b0, trip}, 2'b00);
    src <= 10'h0;
    wreg(5'h08, 32'h0);
    $display("limit and trip done");
    // Every divider code, events before the start match are not counted
    for (int n = 0; n < 8; n++) begin
      wreg(5'h00, {16'h0, n[2:0], 7'h0, 6'(n * 5 + 1)});
      base = trig_seen;
      repeat (3) pulse_ev();
      @(posedge clk_i) roll <= 6'(n * 5 + 1);
      @(posedge clk_i) roll <= 6'h3F;
      repeat (16) pulse_ev();
      cyc(3);
      cmp_word(32'(trig_seen - base), 32'(16 / (n + 1)));
    end
    $display("trigger done");
    // Interrupt: sticky status, masking, clearing
    rchk(5'h0C, 32'h7);
    cyc(2);
    cmp_bits({1'b0, irq}, 2'b00);
    wreg(5'h14, 32'h4);
    cyc(2);
    cmp_bits({1'b0, irq}, 2'b01);
    wreg(5'h10, 32'h4);
    rchk(5'h0C, 32'h3);
    cyc(2);
    cmp_bits({1'b0, irq}, 2'b00);
    wreg(5'h10, 32'h3);
    rchk(5'h0C, 32'h0);
    $display("interrupt done");
    // Reset in mid-run returns registers to zero
    wreg(5'h04, 32'hC400);
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk(5'h04, 32'h0);
    $display("second reset done");
    test_done();
  end
endmodule

`default_nettype wire
